// [port_pin_config_map.vh]
`ifndef PORT_PIN_CONFIG_MAP_VH
`define PORT_PIN_CONFIG_MAP_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_PORT3_DATA 8'hB0
`define IDX_MODE0 8'hB1
`define IDX_MODE0B 8'hB2
`define IDX_MODE1 8'hB3
`define IDX_MODE1B 8'hB4
`define IDX_PAGE_CTRL 8'hC0
`define IDX_PORT0_DATA 8'hC1
`define IDX_PORT1_DATA 8'hC2

// ==========================================================
// Field positions
`define BIT_PAGE_SEL 0
`define BIT_INT_OSC 1
`define BIT_PORT3_PIN 0

// ==========================================================
// Reset values
`define RST_MODE_A 8'hFF
`define RST_MODE_B 8'h00
`define RST_INPUT_TYPE 8'h00
`define RST_SLEW 8'h00
`define RST_PORT1_MODE_B 8'h00
`define RST_PORT_DATA 8'hFF
`define RST_PORT3_DATA 1'h1
`define RST_PAGE_SEL 1'h0
`define RST_INT_OSC 1'h1

// ==========================================================
// Mode encodings {mode_a, mode_b}
`define MODE_QUASI 2'h0
`define MODE_PUSH_PULL 2'h1
`define MODE_INPUT_ONLY 2'h2
`define MODE_OPEN_DRAIN 2'h3

// ==========================================================
// Bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [sync2.v]
module sync2 #(
  parameter WIDTH = 8
) (
  // Clock and control
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // ==========================================================
  // Two-stage synchroniser; first stage feeds only the second
  reg [WIDTH-1:0] meta_r;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// [pin_cell.v]
`include "port_pin_config_map.vh"

module pin_cell (
  // Clock and control
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // Configuration
  input wire mode_a,
  input wire mode_b,
  input wire data,
  // Pad side
  output reg pin_out,
  output reg pin_oe_n,
  output reg pullup_en
);

  // ==========================================================
  // Pad driver; reset leaves the pad released
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out <= 1'b1;
      pin_oe_n <= 1'b1;
      pullup_en <= 1'b0;
    end
    else if (ce)
    begin
      pin_out <= data;
      case ({mode_a, mode_b})
        `MODE_QUASI:
        begin
          // Only low is driven hard; high relies on the weak pull-up
          pin_oe_n <= data;
          pullup_en <= 1'b1;
        end
        `MODE_PUSH_PULL:
        begin
          pin_oe_n <= 1'b0;
          pullup_en <= 1'b0;
        end
        `MODE_OPEN_DRAIN:
        begin
          pin_oe_n <= data;
          pullup_en <= 1'b0;
        end
        default:
        begin
          pin_oe_n <= 1'b1;
          pullup_en <= 1'b0;
        end
      endcase
    end
  end

endmodule

// [port_pin_config_regs.v]
// Function
// - Each port 0 and port 1 pin's mode comes from its bits in select registers A and B.
// - Port 3 data bits 7 down to 1 always read zero.
// - Port 3 pin is general I/O only with the internal oscillator.
// - Otherwise the pin feeds the oscillator; writes ignored, reads zero.
// - Input-type bit picks TTL input at 0, Schmitt input at 1.
// - Port 0 slew bit picks normal edge at 0, fast edge at 1.
// - Reset sets mode select A of ports 0 and 1 to all ones.
// - Reset clears port 0 B, input-type, slew and port 1 input-type.
// - Page 0 of a shared index is mode select, page 1 the other.
`include "port_pin_config_map.vh"

module port_pin_config_regs #(
  parameter ADDR_W = 12
) (
  // Clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // Write address channel
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // Write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // Write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read address channel
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // Read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Port 0 pads
  input wire [7:0] port0_pin_in,
  output wire [7:0] port0_pin_out,
  output wire [7:0] port0_pin_oe_n,
  output wire [7:0] port0_pullup_en,
  output reg [7:0] port0_schmitt_en,
  output reg [7:0] port0_fast_slew,
  // Port 1 pads
  input wire [7:0] port1_pin_in,
  output wire [7:0] port1_pin_out,
  output wire [7:0] port1_pin_oe_n,
  output wire [7:0] port1_pullup_en,
  output reg [7:0] port1_schmitt_en,
  // Port 3 pad
  input wire port3_bit0_pin_in,
  output wire port3_bit0_pin_out,
  output wire port3_bit0_pin_oe_n,
  output wire port3_bit0_pullup_en,
  output reg external_oscillator_input
);

  // ==========================================================
  // Register storage
  reg [7:0] port0_mode_select_a_r;
  reg [7:0] port0_mode_select_b_r;
  reg [7:0] port0_slew_select_r;
  reg [7:0] port1_mode_select_a_r;
  reg [7:0] port1_mode_select_b_r;
  reg [7:0] port0_data_r;
  reg [7:0] port1_data_r;
  reg port3_data_r;
  reg page_sel_r;
  reg int_osc_r;

  // Bus holding registers
  reg [ADDR_W-1:0] aw_addr_r;
  reg aw_held_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_held_r;

  // Synchronised pad levels
  wire [7:0] port0_pin_sync;
  wire [7:0] port1_pin_sync;
  wire [0:0] port3_pin_sync;

  // ==========================================================
  // Pad input synchronisers
  sync2 #(
    .WIDTH(8)
  ) u_sync_port0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in(port0_pin_in),
    .sync_out(port0_pin_sync)
  );

  sync2 #(
    .WIDTH(8)
  ) u_sync_port1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in(port1_pin_in),
    .sync_out(port1_pin_sync)
  );

  sync2 #(
    .WIDTH(1)
  ) u_sync_port3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in(port3_bit0_pin_in),
    .sync_out(port3_pin_sync)
  );

  // ==========================================================
  // Pad drivers, one cell per pin
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_pin
      pin_cell u_p0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .mode_a(port0_mode_select_a_r[g]),
        .mode_b(port0_mode_select_b_r[g]),
        .data(port0_data_r[g]),
        .pin_out(port0_pin_out[g]),
        .pin_oe_n(port0_pin_oe_n[g]),
        .pullup_en(port0_pullup_en[g])
      );
      pin_cell u_p1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .mode_a(port1_mode_select_a_r[g]),
        .mode_b(port1_mode_select_b_r[g]),
        .data(port1_data_r[g]),
        .pin_out(port1_pin_out[g]),
        .pin_oe_n(port1_pin_oe_n[g]),
        .pullup_en(port1_pullup_en[g])
      );
    end
  endgenerate

  // Port 3 is quasi-bidirectional as general I/O, released otherwise
  pin_cell u_p3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .mode_a(~int_osc_r),
    .mode_b(1'b0),
    .data(port3_data_r),
    .pin_out(port3_bit0_pin_out),
    .pin_oe_n(port3_bit0_pin_oe_n),
    .pullup_en(port3_bit0_pullup_en)
  );

  // ==========================================================
  // Write decode
  wire [7:0] w_idx;
  wire do_write;
  wire w_lane0;
  reg w_hit;

  assign w_idx = aw_addr_r[9:2];
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign w_lane0 = w_strb_r[0];

  always @*
  begin
    case (w_idx)
      `IDX_PORT3_DATA,
      `IDX_MODE0,
      `IDX_MODE0B,
      `IDX_MODE1,
      `IDX_PAGE_CTRL,
      `IDX_PORT0_DATA,
      `IDX_PORT1_DATA:
        w_hit = 1'b1;
      // Page 1 of this index holds nothing in this block
      `IDX_MODE1B:
        w_hit = !page_sel_r;
      default:
        w_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Write channel handshake and register updates
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_addr_r <= {ADDR_W{1'b0}};
      aw_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      w_held_r <= 1'b0;
      port0_mode_select_a_r <= `RST_MODE_A;
      port1_mode_select_a_r <= `RST_MODE_A;
      port0_mode_select_b_r <= `RST_MODE_B;
      port0_schmitt_en <= `RST_INPUT_TYPE;
      port0_slew_select_r <= `RST_SLEW;
      port1_schmitt_en <= `RST_INPUT_TYPE;
      port1_mode_select_b_r <= `RST_PORT1_MODE_B;
      port0_data_r <= `RST_PORT_DATA;
      port1_data_r <= `RST_PORT_DATA;
      port3_data_r <= `RST_PORT3_DATA;
      page_sel_r <= `RST_PAGE_SEL;
      int_osc_r <= `RST_INT_OSC;
    end
    else if (ce)
    begin
      // Ready is a one-cycle pulse so each channel takes one item
      s_axi_awready <= s_axi_awvalid && !aw_held_r && !s_axi_awready;
      s_axi_wready <= s_axi_wvalid && !w_held_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? `RESP_OKAY : `RESP_SLVERR;
        // Bits sit in byte lane 0 only; other lanes are don't-care
        if (w_hit && w_lane0)
        begin
          case (w_idx)
            `IDX_PORT3_DATA:
              if (int_osc_r)
                port3_data_r <= w_data_r[`BIT_PORT3_PIN];
            `IDX_MODE0:
              if (page_sel_r)
                port0_schmitt_en <= w_data_r[7:0];
              else
                port0_mode_select_a_r <= w_data_r[7:0];
            `IDX_MODE0B:
              if (page_sel_r)
                port0_slew_select_r <= w_data_r[7:0];
              else
                port0_mode_select_b_r <= w_data_r[7:0];
            `IDX_MODE1:
              if (page_sel_r)
                port1_schmitt_en <= w_data_r[7:0];
              else
                port1_mode_select_a_r <= w_data_r[7:0];
            `IDX_MODE1B:
              port1_mode_select_b_r <= w_data_r[7:0];
            `IDX_PAGE_CTRL:
            begin
              page_sel_r <= w_data_r[`BIT_PAGE_SEL];
              int_osc_r <= w_data_r[`BIT_INT_OSC];
            end
            `IDX_PORT0_DATA:
              port0_data_r <= w_data_r[7:0];
            `IDX_PORT1_DATA:
              port1_data_r <= w_data_r[7:0];
            default:
              port3_data_r <= port3_data_r;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Pad control outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port0_fast_slew <= `RST_SLEW;
      external_oscillator_input <= !`RST_INT_OSC;
    end
    else if (ce)
    begin
      port0_fast_slew <= port0_slew_select_r;
      external_oscillator_input <= !int_osc_r;
    end
  end

  // ==========================================================
  // Read decode
  wire [7:0] r_idx;
  reg [7:0] r_data;
  reg r_hit;

  assign r_idx = s_axi_araddr[9:2];

  always @*
  begin
    r_data = 8'h00;
    r_hit = 1'b1;
    case (r_idx)
      // Upper bits are reserved and stay zero
      `IDX_PORT3_DATA:
        r_data = {7'h00, port3_pin_sync[0] & int_osc_r};
      `IDX_MODE0:
        r_data = page_sel_r ? port0_schmitt_en
                            : port0_mode_select_a_r;
      `IDX_MODE0B:
        r_data = page_sel_r ? port0_slew_select_r
                            : port0_mode_select_b_r;
      `IDX_MODE1:
        r_data = page_sel_r ? port1_schmitt_en
                            : port1_mode_select_a_r;
      `IDX_MODE1B:
      begin
        r_hit = !page_sel_r;
        r_data = page_sel_r ? 8'h00 : port1_mode_select_b_r;
      end
      `IDX_PAGE_CTRL:
        r_data = {6'h00, int_osc_r, page_sel_r};
      // Data reads return the pad level, as on a real port
      `IDX_PORT0_DATA:
        r_data = port0_pin_sync;
      `IDX_PORT1_DATA:
        r_data = port1_pin_sync;
      default:
        r_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Read channel handshake
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, r_data};
        s_axi_rresp <= r_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [port_pin_config_properties.sv]
// ==========================================
// Bus and pad checks on the top ports
module port_pin_config_properties #(
  parameter ADDR_W = 12
) (
  // Bus
  input wire aclk, aresetn, s_axi_awvalid, s_axi_awready,
  input wire s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [31:0] s_axi_rdata,
  // Pads
  input wire [7:0] port0_pin_out, port0_pin_oe_n, port0_pullup_en,
  input wire [7:0] port1_pin_oe_n, port1_pullup_en,
  input wire [7:0] port0_schmitt_en, port1_schmitt_en, port0_fast_slew,
  input wire port3_bit0_pin_oe_n, external_oscillator_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence port3_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h2C0;
  endsequence
  sequence port3_osc_rd;
    port3_rd ##0 external_oscillator_input;
  endsequence
  AST_PORT3_RESERVED: assert property
    (port3_rd |=> s_axi_rvalid && s_axi_rdata[7:1] == 7'h00)
    else $error("port3 reserved bits not zero");
  AST_PORT3_OSC_READ: assert property
    (port3_osc_rd |=> s_axi_rdata[0] == 1'b0)
    else $error("port3 pin read nonzero under oscillator");
  AST_OSC_RELEASE: assert property
    (external_oscillator_input [*3] |-> port3_bit0_pin_oe_n)
    else $error("port3 pin driven while oscillator owns it");
  AST_QUASI_OD: assert property
    ((port0_pullup_en & (port0_pin_oe_n ^ port0_pin_out)) == 8'h00)
    else $error("quasi pin drive not following data");
  AST_RST_MODE: assert property
    ($rose(aresetn) |-> (port0_pin_oe_n == 8'hFF
      && port1_pin_oe_n == 8'hFF && port1_pullup_en == 8'h00) [*3])
    else $error("pins not input only after reset");
  AST_RST_TYPE: assert property
    ($rose(aresetn) |-> ##1 port0_schmitt_en == 8'h00
      && port1_schmitt_en == 8'h00 && port0_fast_slew == 8'h00)
    else $error("input type or slew not cleared by reset");
  AST_WR_RESP: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_RD_RESP: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_NO_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
endmodule

// [pad_model.sv]
// ==========================================
// Pads and board
module pad_model #(
  parameter W = 8
) (
  input wire aclk,
  input wire [W-1:0] out, oe_n, pu, ext, ext_en,
  output logic [W-1:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pad flips every cycle so a stale value never passes
  logic t = 1'b0;
  always @(posedge aclk) t <= ~t;
  assign lvl = (~oe_n & out)
    | (oe_n & (pu | (ext_en & ext) | (~ext_en & {W{t}})));
endmodule

// [port_pin_config_regs_tb.sv]
`include "port_pin_config_map.vh"
// ==========================================
// Testbench
module port_pin_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic pg; logic [11:0] a; logic [7:0] d, e;
    logic [1:0] r;} row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] port0_pin_in, port0_pin_out, port0_pin_oe_n;
  logic [7:0] port0_pullup_en, port0_schmitt_en, port0_fast_slew;
  logic [7:0] port1_pin_in, port1_pin_out, port1_pin_oe_n;
  logic [7:0] port1_pullup_en, port1_schmitt_en;
  logic port3_bit0_pin_in, port3_bit0_pin_out, port3_bit0_pin_oe_n;
  logic port3_bit0_pullup_en, external_oscillator_input;
  logic ce;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [7:0] ext0, ext_en0;
  logic ext3, ext_en3;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  row_t rows [10] = '{
    '{0, 12'h2C4, 8'hF0, 8'hF0, `RESP_OKAY},
    '{0, 12'h2C8, 8'hCC, 8'hCC, `RESP_OKAY},
    '{1, 12'h2C4, 8'h5A, 8'h5A, `RESP_OKAY},
    '{1, 12'h2C8, 8'h96, 8'h96, `RESP_OKAY},
    '{0, 12'h2CC, 8'h00, 8'h00, `RESP_OKAY},
    '{0, 12'h2D0, 8'hFF, 8'hFF, `RESP_OKAY},
    '{1, 12'h2CC, 8'h3C, 8'h3C, `RESP_OKAY},
    '{1, 12'h2D0, 8'h12, 8'h00, `RESP_SLVERR},
    '{0, 12'h3FC, 8'h77, 8'h00, `RESP_SLVERR},
    '{0, 12'h2C0, 8'hFF, 8'h01, `RESP_OKAY}};
  row_t rst [7] = '{'{0, 12'h2C4, 0, 8'hFF, 0}, '{0, 12'h2C8, 0, 0, 0},
    '{0, 12'h2CC, 0, 8'hFF, 0}, '{0, 12'h2D0, 0, 0, 0},
    '{1, 12'h2C4, 0, 0, 0}, '{1, 12'h2C8, 0, 0, 0}, '{1, 12'h2CC, 0, 0, 0}};
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // The port 1 and port 3 board sides stay fixed; port 1 never drives the pads
  port_pin_config_regs i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port0_pin_in, .port0_pin_out,
    .port0_pin_oe_n, .port0_pullup_en, .port0_schmitt_en, .port0_fast_slew,
    .port1_pin_in, .port1_pin_out, .port1_pin_oe_n, .port1_pullup_en,
    .port1_schmitt_en, .port3_bit0_pin_in, .port3_bit0_pin_out,
    .port3_bit0_pin_oe_n, .port3_bit0_pullup_en, .external_oscillator_input);
  pad_model #(.W(8)) i_pad0 (.aclk, .out(port0_pin_out),
    .oe_n(port0_pin_oe_n), .pu(port0_pullup_en), .ext(ext0),
    .ext_en(ext_en0), .lvl(port0_pin_in));
  pad_model #(.W(8)) i_pad1 (.aclk, .out(port1_pin_out),
    .oe_n(port1_pin_oe_n), .pu(port1_pullup_en), .ext(8'h00),
    .ext_en(8'h00), .lvl(port1_pin_in));
  pad_model #(.W(1)) i_pad3 (.aclk, .out(port3_bit0_pin_out),
    .oe_n(port3_bit0_pin_oe_n), .pu(port3_bit0_pullup_en), .ext(ext3),
    .ext_en(ext_en3), .lvl(port3_bit0_pin_in));
  task summarize;
    $display("Tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      num_errors++;
      summarize;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Page writes keep the internal oscillator selected
  task pg(input logic p);
    wr(12'h300, {30'h0, 1'b1, p});
  endtask
  task settle;
    repeat (4) @(posedge aclk);
  endtask
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    {ext0, ext_en0} = 16'h00FF;
    // The oscillator side pulls the pad high whenever it is released
    {ext3, ext_en3} = 2'h3;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      pg(rows[i].pg);
      wr(rows[i].a, {24'h0, rows[i].d});
      chk($sformatf("bresp %0d", i), rows[i].r, r);
      rd(rows[i].a);
      chk($sformatf("rresp %0d", i), rows[i].r, r);
      chk($sformatf("rdata %0d", i), rows[i].e, d);
    end
    rd(12'h2C4);
    chk("mode a kept", 8'hF0, d);
    wr(12'h304, 32'h55);
    wr(12'h308, 32'hA5);
    settle;
    chk("port0 oe_n", 8'h71, port0_pin_oe_n);
    chk("port0 pullup", 8'h03, port0_pullup_en);
    chk("port0 out", 8'h55, port0_pin_out);
    chk("port1 oe_n", 8'h00, port1_pin_oe_n);
    chk("port1 pullup", 8'h00, port1_pullup_en);
    chk("port0 schmitt", 8'h5A, port0_schmitt_en);
    chk("port1 schmitt", 8'h3C, port1_schmitt_en);
    chk("port0 slew", 8'h96, port0_fast_slew);
    rd(12'h304);
    chk("port0 level", 8'h05, d);
    rd(12'h308);
    chk("port1 level", 8'hA5, d);
    wr(12'h2C0, 32'h0);
    settle;
    chk("port3 out", 1'b0, port3_bit0_pin_out);
    chk("port3 oe_n", 1'b0, port3_bit0_pin_oe_n);
    chk("port3 pullup", 1'b1, port3_bit0_pullup_en);
    wr(12'h300, 32'h0);
    wr(12'h2C0, 32'h1);
    settle;
    chk("osc input", 1'b1, external_oscillator_input);
    chk("port3 released", 1'b1, port3_bit0_pin_oe_n);
    rd(12'h2C0);
    chk("port3 read osc", 8'h00, d);
    wr(12'h300, 32'h2);
    settle;
    chk("port3 write ignored", 1'b0, port3_bit0_pin_out);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    chk("port0 oe_n reset", 8'hFF, port0_pin_oe_n);
    ext0 <= 8'h3C;
    foreach (rst[i])
    begin
      pg(rst[i].pg);
      rd(rst[i].a);
      chk($sformatf("reset %0d", i), rst[i].e, d);
    end
    rd(12'h304);
    chk("port0 input only level", 8'h3C, d);
    // Strobe without lane 0 is answered but changes nothing
    s_axi_wstrb <= 4'hE;
    wr(12'h2C4, 32'hFF);
    chk("bresp no lane 0", `RESP_OKAY, r);
    s_axi_wstrb <= 4'hF;
    rd(12'h2C4);
    chk("input type kept", 8'h00, d);
    // Clock enable low must hold off the bus handshake
    ce <= 1'b0;
    fork
      wr(12'h304, 32'hAA);
      begin
        repeat (5) @(posedge aclk);
        chk("awready frozen", 1'b0, s_axi_awready);
        ce <= 1'b1;
      end
    join
    settle;
    chk("port0 out after freeze", 8'hAA, port0_pin_out);
    summarize;
  end
endmodule
bind port_pin_config_regs port_pin_config_properties #(.ADDR_W(ADDR_W))
  i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_araddr,
  .s_axi_rdata, .port0_pin_out, .port0_pin_oe_n, .port0_pullup_en,
  .port1_pin_oe_n, .port1_pullup_en, .port0_schmitt_en, .port1_schmitt_en,
  .port0_fast_slew, .port3_bit0_pin_oe_n, .external_oscillator_input);
